// >>> rtl/gate_pkg.sv
// Shared constants for the gate input decoder and its controller end
package gate_pkg;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_INDEP = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h3;
  localparam logic [2:0] ST_STOP = 3'h0;
  localparam logic [2:0] ST_ALIGN = 3'h7;
  localparam logic [2:0] ST_BC = 3'h6;
  localparam logic [2:0] ST_AC = 3'h4;
  localparam logic [2:0] ST_AB = 3'h5;
  localparam logic [2:0] ST_CB = 3'h1;
  localparam logic [2:0] ST_CA = 3'h3;
  localparam logic [2:0] ST_BA = 3'h2;
  // Controller-side register offsets over APB
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GATES = 8'h04;
  localparam logic [7:0] OFF_SERIAL = 8'h08;
  // Control word field positions
  localparam int CTRL_PWM = 0;
  localparam int CTRL_STATE = 1;
  localparam int CTRL_DIR = 4;
  localparam int CTRL_BRAKE_N = 5;
  localparam int CTRL_INDEP = 6;
  localparam logic [31:0] CTRL_RESET = 32'h00000020;
  // Pin reset value and last bit count on the device end; SER_RESET is the controller end's serial register reset
  localparam logic [5:0] PINS_RESET = 6'h20;
  localparam logic [2:0] SER_RESET = 3'h1;
  localparam logic [3:0] SER_LAST_BIT = 4'hF;
endpackage

// >>> rtl/gate_link_if.sv
// Pin-level link between motor controller and gate decoder
`timescale 1ns/10ps
`default_nettype none
interface gate_link_if;
  logic phase_a_high_in;
  logic phase_a_low_in;
  logic phase_b_high_in;
  logic phase_b_low_in;
  logic phase_c_high_in;
  logic phase_c_low_in;
  logic serial_select_n;
  logic serial_clk;
  logic serial_din;
  logic serial_dout_o;
  logic serial_dout_oe;
  // Open-drain data line, pulled up when released
  wire serial_dout_line = serial_dout_oe ? serial_dout_o : 1'b1;
  modport device (
    input phase_a_high_in, phase_a_low_in, phase_b_high_in,
    input phase_b_low_in, phase_c_high_in, phase_c_low_in,
    input serial_select_n, serial_clk, serial_din,
    output serial_dout_o, serial_dout_oe
  );
  modport ctrl (
    output phase_a_high_in, phase_a_low_in, phase_b_high_in,
    output phase_b_low_in, phase_c_high_in, phase_c_low_in,
    output serial_select_n, serial_clk, serial_din,
    input serial_dout_line
  );
endinterface
`default_nettype wire

// >>> rtl/gate_decoder.sv
// Gate driver input decoder: single-PWM commutation and independent mode
`timescale 1ns/10ps
`default_nettype none
module gate_decoder (
  input wire logic pclk,
  input wire logic presetn,
  gate_link_if.device link,
  input wire logic [1:0] mode,
  input wire logic single_pwm_rectify_sel,
  input wire logic [15:0] serial_tx_word,
  output logic [15:0] serial_rx_word,
  output logic serial_rx_valid,
  output logic [2:0] high_gate_out,
  output logic [2:0] low_gate_out
);
  logic [5:0] in_q;
  logic [2:0] st;
  logic pwm;
  logic [2:0] src;
  logic [2:0] snk;
  logic [2:0] hi_d;
  logic [2:0] lo_d;
  logic sck_q;
  logic [3:0] cnt_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic dout_q;

  // Sample inputs so decode never sees a half-updated pattern
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_q <= gate_pkg::PINS_RESET;
    else
      in_q <= {link.phase_c_low_in, link.phase_c_high_in,
               link.phase_b_low_in, link.phase_b_high_in,
               link.phase_a_low_in, link.phase_a_high_in};
  end

  // State word and PWM; direction inverts only the six true steps
  // Stop and align are each other's inverse, so they skip the flip
  always_comb
  begin
    pwm = in_q[0];
    st = {in_q[1], in_q[2], in_q[3]};
    if (in_q[4] && st != gate_pkg::ST_STOP && st != gate_pkg::ST_ALIGN)
      st = ~st;
  end

  // Source and sink phase per step, bit 0 is phase A
  always_comb
  begin
    src = 3'h0;
    snk = 3'h0;
    unique case (st)
      gate_pkg::ST_STOP:
      begin
        src = 3'h0;
        snk = 3'h0;
      end
      gate_pkg::ST_ALIGN:
      begin
        src = 3'h1;
        snk = 3'h6;
      end
      gate_pkg::ST_BC:
      begin
        src = 3'h2;
        snk = 3'h4;
      end
      gate_pkg::ST_AC:
      begin
        src = 3'h1;
        snk = 3'h4;
      end
      gate_pkg::ST_AB:
      begin
        src = 3'h1;
        snk = 3'h2;
      end
      gate_pkg::ST_CB:
      begin
        src = 3'h4;
        snk = 3'h2;
      end
      gate_pkg::ST_CA:
      begin
        src = 3'h4;
        snk = 3'h1;
      end
      gate_pkg::ST_BA:
      begin
        src = 3'h2;
        snk = 3'h1;
      end
    endcase
  end

  // Gate pattern by mode; brake overrides single-PWM pattern
  always_comb
  begin
    hi_d = 3'h0;
    lo_d = 3'h0;
    if (mode == gate_pkg::MODE_SINGLE)
    begin
      hi_d = pwm ? src : 3'h0;
      if (single_pwm_rectify_sel)
        lo_d = snk;
      else
        lo_d = snk | (pwm ? 3'h0 : src);
      if (!in_q[5])
      begin
        hi_d = 3'h0;
        lo_d = 3'h7;
      end
    end
    else if (mode == gate_pkg::MODE_INDEP)
    begin
      // No shoot-through guard here; both-on passes straight through
      hi_d = {in_q[4], in_q[2], in_q[0]};
      lo_d = {in_q[5], in_q[3], in_q[1]};
    end
  end

  // Gate commands from flops
  // Registered so decode hazards never reach the gate pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_gate_out <= 3'h0;
      low_gate_out <= 3'h0;
    end
    else
    begin
      high_gate_out <= hi_d;
      low_gate_out <= lo_d;
    end
  end

  // Serial port on the four shared pins, sampled on pclk
  // Edges are found on the sampled clock, so it must run well below pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_q <= 1'b0;
      cnt_q <= 4'h0;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      dout_q <= 1'b1;
      serial_rx_word <= 16'h0000;
      serial_rx_valid <= 1'b0;
    end
    else
    begin
      sck_q <= link.serial_clk;
      serial_rx_valid <= 1'b0;
      if (link.serial_select_n)
      begin
        cnt_q <= 4'h0;
        tx_q <= serial_tx_word;
        dout_q <= 1'b1;
      end
      else if (link.serial_clk && !sck_q)
      begin
        // Rising edge: shift out then capture, MSB first
        dout_q <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
        rx_q <= {rx_q[14:0], link.serial_din};
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == gate_pkg::SER_LAST_BIT)
        begin
          serial_rx_word <= {rx_q[14:0], link.serial_din};
          serial_rx_valid <= 1'b1;
        end
      end
    end
  end

  // Open drain: only pull low, released otherwise
  // The pull-up makes the high level; driving high would fight the bus
  assign link.serial_dout_o = 1'b0;
  assign link.serial_dout_oe = !link.serial_select_n && !dout_q;
endmodule // gate_decoder
`default_nettype wire

// >>> rtl/gate_controller.sv
// Controller end: APB registers drive the decoder's input pins
`timescale 1ns/10ps
`default_nettype none
module gate_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gate_link_if.ctrl link
);
  logic [31:0] ctrl_q;
  logic [5:0] gates_q;
  logic [2:0] ser_q;
  logic wr;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == gate_pkg::OFF_CTRL ||
    paddr == gate_pkg::OFF_GATES || paddr == gate_pkg::OFF_SERIAL);

  // Writable registers; brake pin resets released, direction low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= gate_pkg::CTRL_RESET;
      gates_q <= 6'h00;
      ser_q <= gate_pkg::SER_RESET;
    end
    else if (wr)
    begin
      if (paddr == gate_pkg::OFF_CTRL)
        ctrl_q <= {25'h0000000, pwdata[6:0]};
      if (paddr == gate_pkg::OFF_GATES)
        gates_q <= pwdata[5:0]; // software's duty
      if (paddr == gate_pkg::OFF_SERIAL)
        ser_q <= pwdata[2:0];
    end
  end

  // Read mux; bit 3 of serial shows the open-drain line
  always_comb
  begin
    prdata = 32'h00000000;
    unique case (paddr)
      gate_pkg::OFF_CTRL: prdata = ctrl_q;
      gate_pkg::OFF_GATES: prdata = {26'h0000000, gates_q};
      gate_pkg::OFF_SERIAL: prdata = {28'h0000000, link.serial_dout_line,
        ser_q};
      default: prdata = 32'h00000000;
    endcase
  end

  // Pins: single-PWM word or independent gates; software must idle
  // all to zero before any mode change
  always_comb
  begin
    if (ctrl_q[gate_pkg::CTRL_INDEP])
    begin
      {link.phase_c_low_in, link.phase_c_high_in, link.phase_b_low_in,
       link.phase_b_high_in, link.phase_a_low_in, link.phase_a_high_in}
        = gates_q;
    end
    else
    begin
      link.phase_a_high_in = ctrl_q[gate_pkg::CTRL_PWM];
      link.phase_a_low_in = ctrl_q[gate_pkg::CTRL_STATE + 2];
      link.phase_b_high_in = ctrl_q[gate_pkg::CTRL_STATE + 1];
      link.phase_b_low_in = ctrl_q[gate_pkg::CTRL_STATE];
      link.phase_c_high_in = ctrl_q[gate_pkg::CTRL_DIR];
      link.phase_c_low_in = ctrl_q[gate_pkg::CTRL_BRAKE_N];
    end
  end

  // Serial pins driven straight from register bits
  assign link.serial_select_n = ser_q[0];
  assign link.serial_clk = ser_q[1];
  assign link.serial_din = ser_q[2];
endmodule // gate_controller
`default_nettype wire

// >>> bench/gate_link_props.sv
// Checks on the link pins and the decoder gate outputs
`timescale 1ns/10ps
`default_nettype none
module gate_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic single_pwm_rectify_sel,
  input wire logic phase_a_high_in,
  input wire logic phase_a_low_in,
  input wire logic phase_b_high_in,
  input wire logic phase_b_low_in,
  input wire logic phase_c_high_in,
  input wire logic phase_c_low_in,
  input wire logic serial_select_n,
  input wire logic serial_dout_o,
  input wire logic serial_dout_oe,
  input wire logic [2:0] high_gate_out,
  input wire logic [2:0] low_gate_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Gates lag the pins by two edges, so each window is three samples
  wire logic [2:0] st = {phase_a_low_in, phase_b_high_in, phase_b_low_in};
  wire logic [2:0] hi = {phase_c_high_in, phase_b_high_in, phase_a_high_in};
  wire logic [2:0] lo = {phase_c_low_in, phase_b_low_in, phase_a_low_in};
  wire logic run = mode == gate_pkg::MODE_SINGLE && phase_c_low_in;
  wire logic ab = run && (phase_c_high_in ? ~st : st) == 3'h5;
  wire logic [5:0] g = {high_gate_out, low_gate_out};
  brake_all_a:
    assert property ((mode == gate_pkg::MODE_SINGLE && !phase_c_low_in) [*3]
      |-> g == 6'h07) else $error("brake gates wrong");
  indep_follow_a:
    assert property ((mode == gate_pkg::MODE_INDEP) [*3]
      |-> g == {$past(hi, 2), $past(lo, 2)}) else $error("indep gates wrong");
  stop_off_a:
    assert property ((run && st == 3'h0) [*3] |-> g == 6'h00)
      else $error("stop gates wrong");
  sync_pwm_a:
    assert property ((ab && !single_pwm_rectify_sel) [*3] |-> g ==
      {2'h0, $past(phase_a_high_in, 2), 2'h1, !$past(phase_a_high_in, 2)})
      else $error("sync gates wrong");
  async_pwm_a:
    assert property ((ab && single_pwm_rectify_sel) [*3]
      |-> g == {2'h0, $past(phase_a_high_in, 2), 3'h2})
      else $error("async gates wrong");
  reset_pins_a:
    assert property ($rose(presetn) |-> phase_c_low_in && serial_select_n
      && !phase_c_high_in) else $error("reset pins wrong");
  drain_only_a:
    assert property (serial_dout_oe |-> !serial_dout_o)
      else $error("data driven high");
  select_release_a:
    assert property ($fell(serial_select_n) |-> !serial_dout_oe)
      else $error("data held at select");
endmodule // gate_link_props
`default_nettype wire

// >>> bench/tb_top.sv
// Bench joining the APB controller end to the gate decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] mode = 2'h2;
  logic rect = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr;
  logic [2:0] hg, lg;
  logic [15:0] rx;
  logic rxv;
  logic [15:0] pat = 16'h5A3C;
  logic [15:0] txw = 16'hA5C3;
  wire logic [31:0] gates_seen = {26'h0, hg, lg};
  int n_rxv = 0;
  int fail_count = 0;
  int n_checks = 0;
  gate_link_if link ();
  gate_controller gate_controller_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  gate_decoder gate_decoder_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .mode(mode), .single_pwm_rectify_sel(rect),
    .serial_tx_word(txw), .serial_rx_word(rx), .serial_rx_valid(rxv),
    .high_gate_out(hg), .low_gate_out(lg));
  gate_link_props gate_link_props_inst (.pclk(pclk), .presetn(presetn),
    .mode(mode), .single_pwm_rectify_sel(rect),
    .phase_a_high_in(link.phase_a_high_in),
    .phase_a_low_in(link.phase_a_low_in),
    .phase_b_high_in(link.phase_b_high_in),
    .phase_b_low_in(link.phase_b_low_in),
    .phase_c_high_in(link.phase_c_high_in),
    .phase_c_low_in(link.phase_c_low_in),
    .serial_select_n(link.serial_select_n),
    .serial_dout_o(link.serial_dout_o), .serial_dout_oe(link.serial_dout_oe),
    .high_gate_out(hg), .low_gate_out(lg));
  initial forever #5 pclk = ~pclk;
  // Count word-done pulses; exactly one is expected per frame
  always @(posedge pclk)
  begin
    if (rxv === 1'b1)
      n_rxv <= n_rxv + 1;
  end
  // One APB transfer; read data is taken at the pready edge, then
  // one idle edge so psel is never set twice in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Expected {high, low} from control bits: pwm, state, dir, brake_n
  function automatic logic [5:0] expg(input logic [5:0] w, input logic as);
    logic [2:0] s;
    logic [5:0] m;
    s = (w[4] && w[3:1] != 3'h0 && w[3:1] != 3'h7) ? ~w[3:1] : w[3:1];
    case (s)
      3'h6: m = 6'h14;
      3'h4: m = 6'h0C;
      3'h5: m = 6'h0A;
      3'h1: m = 6'h22;
      3'h3: m = 6'h21;
      3'h2: m = 6'h11;
      3'h7: m = 6'h0E;
      default: m = 6'h00;
    endcase
    if (!w[5]) return 6'h07;
    return {w[0] ? m[5:3] : 3'h0, m[2:0] | (as || w[0] ? 3'h0 : m[5:3])};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    logic [5:0] p;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, gate_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", gate_pkg::CTRL_RESET, rdat);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    $display("test registers done");
    // Every state, direction, pwm level, brake and rectification style
    for (int i = 0; i < 128; i++)
    begin
      rect <= i[6];
      apb(1'b1, gate_pkg::OFF_CTRL, {26'h0, i[5:0]});
      repeat (3) @(posedge pclk);
      chk("single gates", {26'h0, expg(i[5:0], i[6])}, gates_seen);
    end
    $display("test single pwm done");
    apb(1'b1, gate_pkg::OFF_CTRL, 32'h0); // all pins low first
    mode <= gate_pkg::MODE_INDEP;
    apb(1'b1, gate_pkg::OFF_CTRL, 32'h60);
    for (int i = 0; i < 4; i++)
    begin
      p = {3{i[1:0]}};
      apb(1'b1, gate_pkg::OFF_GATES, {26'h0, p});
      repeat (3) @(posedge pclk);
      chk("indep gates", {26'h0, {3{p[0]}}, {3{p[1]}}}, gates_seen);
    end
    $display("test independent done");
    for (int i = 15; i >= 0; i--)
    begin
      apb(1'b1, gate_pkg::OFF_SERIAL, {29'h0, pat[i], 2'h0});
      apb(1'b1, gate_pkg::OFF_SERIAL, {29'h0, pat[i], 2'h2});
      apb(1'b0, gate_pkg::OFF_SERIAL, 32'h0);
      chk("serial out", {28'h0, txw[i], pat[i], 2'h2}, rdat);
    end
    apb(1'b1, gate_pkg::OFF_SERIAL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("rx word", {16'h0, pat}, {16'h0, rx});
    chk("rx valid count", 32'h1, n_rxv);
    apb(1'b0, gate_pkg::OFF_SERIAL, 32'h0);
    chk("serial line", 32'h9, rdat);
    $display("test serial done");
    summarize();
  end
  // Whole run needs about 1000 cycles
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
